// *** aes_pkg.sv ***
// Purpose: shared constants and types for the autoneg expansion status bank
// Assumes: AHB-Lite slave, 32-bit word registers, one clock
// Notes: offsets are byte addresses within the slave's window
package aes_pkg;

   localparam int AES_DATA_W = 32;
   localparam int AES_DEC_W = 8;
   localparam int AES_FLD_W = 8;
   localparam int AES_EXP_W = 16;

   // register byte offsets
   localparam logic [AES_DEC_W-1:0] AES_EXP_STATUS_OFS = 8'h00;
   localparam logic [AES_DEC_W-1:0] AES_GEN_STATUS_OFS = 8'h04;
   localparam logic [AES_DEC_W-1:0] AES_MASK_STATUS_OFS = 8'h08;
   localparam logic [AES_DEC_W-1:0] AES_INT_EN_OFS = 8'h0C;
   localparam logic [AES_DEC_W-1:0] AES_LOR_CFG_OFS = 8'h10;
   localparam logic [AES_DEC_W-1:0] AES_STROBE_CTRL_OFS = 8'h14;

   // expansion status field positions
   localparam int AES_EXP_PARTNER_AN_BIT = 0;
   localparam int AES_EXP_PAGE_RX_BIT = 1;
   localparam int AES_EXP_LOCAL_NEXT_BIT = 2;
   localparam int AES_EXP_PARTNER_NEXT_BIT = 3;
   localparam int AES_EXP_FAULT_BIT = 4;
   localparam logic [AES_EXP_W-1:0] AES_EXP_RESET = 16'h0004;

   // general status: virtual read in low byte, latch-low bits in next byte
   localparam int AES_GEN_VIRT_LSB = 0;
   localparam int AES_GEN_LLSC_LSB = 8;

   // latch cell sense
   localparam logic AES_SENSE_HIGH = 1'b0;
   localparam logic AES_SENSE_LOW = 1'b1;

   // ahb transfer type and response
   localparam logic [1:0] AES_HTRANS_NONSEQ = 2'h2;
   localparam logic AES_HRESP_OKAY = 1'b0;
   localparam logic [AES_DATA_W-1:0] AES_RD_ZERO = 32'h00000000;
   localparam logic [AES_FLD_W-1:0] AES_FLD_ZERO = 8'h00;

   // captured address phase
   typedef struct packed {
      logic valid;
      logic write;
      logic [AES_DEC_W-1:0] addr;
   } aes_aphase_t;

   // registered hardware status of the expansion register
   typedef struct packed {
      logic partner_next_page_able;
      logic local_next_page_able;
      logic partner_autoneg_able;
   } aes_exp_ro_t;

endpackage : aes_pkg

// *** aes_sticky_cell.sv ***
// Purpose: vector of latching status bits, high or low sensitive
// Assumes: clear is a one-cycle request per bit
// Notes: a set in the clearing cycle wins, so no event is lost
`timescale 1ns/1ps
module aes_sticky_cell
   import aes_pkg::*;
#(
   parameter int W = 1,
   parameter logic SENSE = AES_SENSE_HIGH
) (
   input wire logic clk_i,
   input wire logic rst_i,
   input wire logic [W-1:0] src_i,
   input wire logic [W-1:0] clr_i,
   output logic [W-1:0] q_o
);

   logic [W-1:0] q_reg;
   logic [W-1:0] q_next;
   wire logic [W-1:0] set_w = (SENSE == AES_SENSE_LOW) ? ~src_i : src_i;

   // set wins over clear
   assign q_next = set_w | (q_reg & ~clr_i);
   assign q_o = q_reg;

   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         q_reg <= '0;
      end else begin
         q_reg <= q_next;
      end
   end

endmodule : aes_sticky_cell

// *** aes_bank.sv ***
// Purpose: autoneg expansion status register and generic field primitives on AHB-Lite
// Assumes: single clock, synchronous active-high reset, word accesses only
// Notes: zero wait state slave; reads commit clear-on-read at the address phase
`timescale 1ns/1ps
module aes_bank
   import aes_pkg::*;
(
   input wire logic MCLK_I,
   input wire logic SYS_RST_I,
   // ahb-lite slave
   input wire logic HSEL_I,
   input wire logic [AES_DATA_W-1:0] HADDR_I,
   input wire logic [1:0] HTRANS_I,
   input wire logic HWRITE_I,
   input wire logic [2:0] HSIZE_I,
   input wire logic [AES_DATA_W-1:0] HWDATA_I,
   input wire logic HREADY_I,
   output logic HREADYOUT_O,
   output logic [AES_DATA_W-1:0] HRDATA_O,
   output logic HRESP_O,
   // autoneg status sources
   input wire logic PARALLEL_DETECT_FAULT_I,
   input wire logic PAGE_RECEIVED_I,
   input wire logic PARTNER_NEXT_PAGE_ABLE_I,
   input wire logic LOCAL_NEXT_PAGE_ABLE_I,
   input wire logic PARTNER_AUTONEG_ABLE_I,
   // generic field sources
   input wire logic [AES_FLD_W-1:0] VIRTUAL_READ_FIELD_I,
   input wire logic [AES_FLD_W-1:0] LATCH_LOW_SRC_I,
   input wire logic [AES_FLD_W-1:0] MASK_SRC_I,
   input wire logic [AES_FLD_W-1:0] STRAP_I,
   // hardware controls
   output logic [AES_FLD_W-1:0] LOR_CFG_O,
   output logic [AES_FLD_W-1:0] STROBE_O,
   output logic EVENT_REQ_O
);

   ////////////////////////////////////////////////////////////////////////////
   // bus address phase

   aes_aphase_t dphase_reg;
   aes_aphase_t dphase_next;
   logic [AES_DATA_W-1:0] hrdata_reg;
   logic [AES_DATA_W-1:0] hrdata_next;
   logic hreadyout_reg;
   logic hresp_reg;

   wire logic take_w = HSEL_I & HREADY_I & (HTRANS_I == AES_HTRANS_NONSEQ);
   wire logic [AES_DEC_W-1:0] a_addr_w = HADDR_I[AES_DEC_W-1:0];
   wire logic rd_take_w = take_w & ~HWRITE_I;

   // hsize unused: only whole-word transfers are issued to this slave
   assign dphase_next.valid = take_w;
   assign dphase_next.write = HWRITE_I;
   assign dphase_next.addr = a_addr_w;

   // read decode on the address phase
   wire logic rd_exp_w = rd_take_w & (a_addr_w == AES_EXP_STATUS_OFS);
   wire logic rd_gen_w = rd_take_w & (a_addr_w == AES_GEN_STATUS_OFS);

   // write decode on the data phase
   wire logic wr_w = dphase_reg.valid & dphase_reg.write;
   wire logic wr_mask_w = wr_w & (dphase_reg.addr == AES_MASK_STATUS_OFS);
   wire logic wr_int_en_w = wr_w & (dphase_reg.addr == AES_INT_EN_OFS);
   wire logic wr_lor_w = wr_w & (dphase_reg.addr == AES_LOR_CFG_OFS);
   wire logic wr_strobe_w = wr_w & (dphase_reg.addr == AES_STROBE_CTRL_OFS);
   wire logic [AES_FLD_W-1:0] wfld_w = HWDATA_I[AES_FLD_W-1:0];

   ////////////////////////////////////////////////////////////////////////////
   // expansion status register

   aes_exp_ro_t exp_ro_reg;
   aes_exp_ro_t exp_ro_next;
   logic [1:0] exp_lh_w;
   logic [AES_EXP_W-1:0] exp_value_w;

   // plain read-only bits go through one register stage
   assign exp_ro_next.partner_next_page_able = PARTNER_NEXT_PAGE_ABLE_I;
   assign exp_ro_next.local_next_page_able = LOCAL_NEXT_PAGE_ABLE_I;
   assign exp_ro_next.partner_autoneg_able = PARTNER_AUTONEG_ABLE_I;

   // bit 1 of the cell is fault, bit 0 page received; a read clears both
   aes_sticky_cell #(
      .W(2),
      .SENSE(AES_SENSE_HIGH)
   ) u_exp_lh (
      .clk_i(MCLK_I),
      .rst_i(SYS_RST_I),
      .src_i({PARALLEL_DETECT_FAULT_I, PAGE_RECEIVED_I}),
      .clr_i({2{rd_exp_w}}),
      .q_o(exp_lh_w)
   );

   // reserved bits tie to zero, no write path exists for this word
   always_comb begin
      exp_value_w = '0;
      exp_value_w[AES_EXP_FAULT_BIT] = exp_lh_w[1];
      exp_value_w[AES_EXP_PARTNER_NEXT_BIT] = exp_ro_reg.partner_next_page_able;
      exp_value_w[AES_EXP_LOCAL_NEXT_BIT] = exp_ro_reg.local_next_page_able;
      exp_value_w[AES_EXP_PAGE_RX_BIT] = exp_lh_w[0];
      exp_value_w[AES_EXP_PARTNER_AN_BIT] = exp_ro_reg.partner_autoneg_able;
   end

   ////////////////////////////////////////////////////////////////////////////
   // generic field primitives

   logic [AES_FLD_W-1:0] llsc_w;
   logic [AES_FLD_W-1:0] lhmk_w;
   logic [AES_FLD_W-1:0] int_en_reg;
   logic [AES_FLD_W-1:0] int_en_next;
   logic [AES_FLD_W-1:0] lor_reg;
   logic [AES_FLD_W-1:0] lor_next;
   logic lor_loaded_reg;
   logic [AES_FLD_W-1:0] strobe_reg;
   logic [AES_FLD_W-1:0] strobe_next;
   logic event_req_reg;
   logic event_req_next;

   // latch on low source level, cleared by reading the general status word
   aes_sticky_cell #(
      .W(AES_FLD_W),
      .SENSE(AES_SENSE_LOW)
   ) u_llsc (
      .clk_i(MCLK_I),
      .rst_i(SYS_RST_I),
      .src_i(LATCH_LOW_SRC_I),
      .clr_i({AES_FLD_W{rd_gen_w}}),
      .q_o(llsc_w)
   );

   // latch on high source level, cleared per bit by a written one
   aes_sticky_cell #(
      .W(AES_FLD_W),
      .SENSE(AES_SENSE_HIGH)
   ) u_lhmk (
      .clk_i(MCLK_I),
      .rst_i(SYS_RST_I),
      .src_i(MASK_SRC_I),
      .clr_i(wr_mask_w ? wfld_w : AES_FLD_ZERO),
      .q_o(lhmk_w)
   );

   assign int_en_next = wr_int_en_w ? wfld_w : int_en_reg;

   // strap capture on the first edge after reset, plain read/write after
   assign lor_next = !lor_loaded_reg ? STRAP_I : (wr_lor_w ? wfld_w : lor_reg);

   // one-cycle strobe; hardware drops it again on the next edge
   assign strobe_next = wr_strobe_w ? wfld_w : AES_FLD_ZERO;

   // enabled mask-clearing sources raise the event request
   assign event_req_next = |(lhmk_w & int_en_reg);

   ////////////////////////////////////////////////////////////////////////////
   // read data mux

   wire logic [AES_DATA_W-1:0] rd_exp_val_w = {{(AES_DATA_W - AES_EXP_W){1'b0}}, exp_value_w};
   logic [AES_DATA_W-1:0] rd_gen_val_w;
   wire logic [AES_DATA_W-1:0] rd_mask_val_w = {{(AES_DATA_W - AES_FLD_W){1'b0}}, lhmk_w};
   wire logic [AES_DATA_W-1:0] rd_int_en_val_w = {{(AES_DATA_W - AES_FLD_W){1'b0}}, int_en_reg};
   wire logic [AES_DATA_W-1:0] rd_lor_val_w = {{(AES_DATA_W - AES_FLD_W){1'b0}}, lor_reg};
   wire logic [AES_DATA_W-1:0] rd_strobe_val_w = {{(AES_DATA_W - AES_FLD_W){1'b0}}, strobe_reg};

   always_comb begin
      rd_gen_val_w = AES_RD_ZERO;
      // virtual field: input wired straight in, no storage stage
      rd_gen_val_w[AES_GEN_VIRT_LSB +: AES_FLD_W] = VIRTUAL_READ_FIELD_I;
      rd_gen_val_w[AES_GEN_LLSC_LSB +: AES_FLD_W] = llsc_w;
   end

   // unmapped addresses read zero with an okay response
   assign hrdata_next =
      !rd_take_w ? hrdata_reg :
      (a_addr_w == AES_EXP_STATUS_OFS) ? rd_exp_val_w :
      (a_addr_w == AES_GEN_STATUS_OFS) ? rd_gen_val_w :
      (a_addr_w == AES_MASK_STATUS_OFS) ? rd_mask_val_w :
      (a_addr_w == AES_INT_EN_OFS) ? rd_int_en_val_w :
      (a_addr_w == AES_LOR_CFG_OFS) ? rd_lor_val_w :
      (a_addr_w == AES_STROBE_CTRL_OFS) ? rd_strobe_val_w :
      AES_RD_ZERO;

   ////////////////////////////////////////////////////////////////////////////
   // registers

   always_ff @(posedge MCLK_I) begin
      if (SYS_RST_I) begin
         dphase_reg <= '0;
         hrdata_reg <= AES_RD_ZERO;
         hreadyout_reg <= 1'b0;
         hresp_reg <= AES_HRESP_OKAY;
      end else begin
         dphase_reg <= dphase_next;
         hrdata_reg <= hrdata_next;
         hreadyout_reg <= 1'b1;
         hresp_reg <= AES_HRESP_OKAY;
      end
   end

   // local next-page bit resets to one so the word reads 0004
   always_ff @(posedge MCLK_I) begin
      if (SYS_RST_I) begin
         exp_ro_reg <= '0;
         exp_ro_reg.local_next_page_able <= AES_EXP_RESET[AES_EXP_LOCAL_NEXT_BIT];
      end else begin
         exp_ro_reg <= exp_ro_next;
      end
   end

   always_ff @(posedge MCLK_I) begin
      if (SYS_RST_I) begin
         int_en_reg <= AES_FLD_ZERO;
         strobe_reg <= AES_FLD_ZERO;
         event_req_reg <= 1'b0;
      end else begin
         int_en_reg <= int_en_next;
         strobe_reg <= strobe_next;
         event_req_reg <= event_req_next;
      end
   end

   // reset loads a constant; the strap is sampled only after release
   always_ff @(posedge MCLK_I) begin
      if (SYS_RST_I) begin
         lor_reg <= AES_FLD_ZERO;
         lor_loaded_reg <= 1'b0;
      end else begin
         lor_reg <= lor_next;
         lor_loaded_reg <= 1'b1;
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // outputs

   assign HREADYOUT_O = hreadyout_reg;
   assign HRDATA_O = hrdata_reg;
   assign HRESP_O = hresp_reg;
   assign LOR_CFG_O = lor_reg;
   assign STROBE_O = strobe_reg;
   assign EVENT_REQ_O = event_req_reg;

endmodule : aes_bank

// *** aes_bank_chk.sv ***
// Purpose: bus and status checks for the autoneg expansion bank
// Assumes: zero wait state slave, one clock, sync reset
// Notes: bound to aes_bank from the bench top
`timescale 1ns/1ps
module aes_bank_chk
   import aes_pkg::*;
(
   input wire logic MCLK_I,
   input wire logic SYS_RST_I,
   input wire logic HSEL_I,
   input wire logic [AES_DATA_W-1:0] HADDR_I,
   input wire logic [1:0] HTRANS_I,
   input wire logic HWRITE_I,
   input wire logic [AES_DATA_W-1:0] HWDATA_I,
   input wire logic HREADY_I,
   input wire logic [AES_DATA_W-1:0] HRDATA_O,
   input wire logic PARALLEL_DETECT_FAULT_I,
   input wire logic PAGE_RECEIVED_I,
   input wire logic PARTNER_NEXT_PAGE_ABLE_I,
   input wire logic LOCAL_NEXT_PAGE_ABLE_I,
   input wire logic PARTNER_AUTONEG_ABLE_I,
   input wire logic [AES_FLD_W-1:0] VIRTUAL_READ_FIELD_I,
   input wire logic [AES_FLD_W-1:0] MASK_SRC_I,
   input wire logic [AES_FLD_W-1:0] STRAP_I,
   input wire logic [AES_FLD_W-1:0] LOR_CFG_O,
   input wire logic [AES_FLD_W-1:0] STROBE_O
);
   default clocking @(posedge MCLK_I); endclocking
   default disable iff (SYS_RST_I);
   ////////////////////////////////////////////////////////////////////////
   logic aph_v_reg, aph_w_reg;
   logic [7:0] aph_a_reg;
   logic [1:0] age_reg;
   wire take = HSEL_I & HREADY_I & (HTRANS_I == AES_HTRANS_NONSEQ);
   wire [7:0] adr = HADDR_I[7:0];
   wire rd_exp = take & !HWRITE_I & (adr == AES_EXP_STATUS_OFS);
   wire dp_wr = aph_v_reg & aph_w_reg;
   // age keeps $past away from values seen inside reset
   always_ff @(posedge MCLK_I) begin
      if (SYS_RST_I) begin
         aph_v_reg <= 1'b0;
         age_reg <= 2'h0;
      end else begin
         aph_v_reg <= take;
         if (age_reg != 2'h3) age_reg <= age_reg + 2'h1;
      end
      aph_w_reg <= HWRITE_I;
      aph_a_reg <= adr;
   end
   ////////////////////////////////////////////////////////////////////////
   sequence fault_then_read;
      PARALLEL_DETECT_FAULT_I ##1 rd_exp;
   endsequence
   sequence page_then_read;
      PAGE_RECEIVED_I ##1 rd_exp;
   endsequence
   sequence two_quiet_reads;
      (rd_exp && !PARALLEL_DETECT_FAULT_I) ##1 !PARALLEL_DETECT_FAULT_I ##1 rd_exp;
   endsequence
   chk_ro_follow: assert property ((age_reg == 2'h3 && rd_exp) |=>
      HRDATA_O[3] == $past(PARTNER_NEXT_PAGE_ABLE_I, 2) &&
      HRDATA_O[2] == $past(LOCAL_NEXT_PAGE_ABLE_I, 2) &&
      HRDATA_O[0] == $past(PARTNER_AUTONEG_ABLE_I, 2)) else $error("ro bit lag wrong");
   chk_reserved_zero: assert property (rd_exp |=> HRDATA_O[31:5] == 27'h0000000)
      else $error("reserved bits set");
   chk_fault_latch: assert property (fault_then_read |=> HRDATA_O[4])
      else $error("fault not latched");
   chk_page_latch: assert property (page_then_read |=> HRDATA_O[1])
      else $error("page not latched");
   chk_read_clears: assert property (two_quiet_reads |=> !HRDATA_O[4])
      else $error("fault kept after read");
   chk_virtual_live: assert property (take && !HWRITE_I &&
      adr == AES_GEN_STATUS_OFS |=> HRDATA_O[7:0] == $past(VIRTUAL_READ_FIELD_I))
      else $error("virtual field not live");
   chk_mask_clear: assert property ((dp_wr && aph_a_reg == AES_MASK_STATUS_OFS &&
      HWDATA_I[7:0] == 8'hFF && MASK_SRC_I == 8'h00) ##1 (take && !HWRITE_I &&
      adr == AES_MASK_STATUS_OFS && MASK_SRC_I == 8'h00) |=> HRDATA_O[7:0] == 8'h00)
      else $error("mask clear failed");
   chk_lor_capture: assert property (!SYS_RST_I && age_reg == 2'h0 |=>
      LOR_CFG_O == $past(STRAP_I))
      else $error("strap not captured");
   chk_strobe_pulse: assert property (dp_wr && aph_a_reg == AES_STROBE_CTRL_OFS |=>
      STROBE_O == $past(HWDATA_I[7:0])) else $error("strobe value wrong");
   chk_strobe_idle: assert property (!(dp_wr && aph_a_reg == AES_STROBE_CTRL_OFS) |=>
      STROBE_O == 8'h00) else $error("strobe not cleared");
endmodule : aes_bank_chk

// *** aes_bank_tb_top.sv ***
// Purpose: directed register tests of the autoneg expansion bank
// Assumes: zero wait state slave, hready fed back from hreadyout
// Notes: hsize tied to word; the bank ignores hsize
`timescale 1ns/1ps
module aes_bank_tb_top
   import aes_pkg::*;
;
   logic clk, rst, hsel, hwrite, hro, hresp, flt, prx, pnp, lnp, pan, evt;
   logic [1:0] htrans;
   logic [31:0] haddr, hwdata, hrdata, d;
   logic [7:0] vrf, llsrc, msrc, strap, lor, stb;
   int error_cnt, comparisons;
   aes_bank dut_u (.MCLK_I(clk), .SYS_RST_I(rst), .HSEL_I(hsel), .HADDR_I(haddr),
      .HTRANS_I(htrans), .HWRITE_I(hwrite), .HSIZE_I(3'h2), .HWDATA_I(hwdata),
      .HREADY_I(hro), .HREADYOUT_O(hro), .HRDATA_O(hrdata), .HRESP_O(hresp),
      .PARALLEL_DETECT_FAULT_I(flt), .PAGE_RECEIVED_I(prx), .PARTNER_NEXT_PAGE_ABLE_I(pnp),
      .LOCAL_NEXT_PAGE_ABLE_I(lnp), .PARTNER_AUTONEG_ABLE_I(pan), .VIRTUAL_READ_FIELD_I(vrf),
      .LATCH_LOW_SRC_I(llsrc), .MASK_SRC_I(msrc), .STRAP_I(strap), .LOR_CFG_O(lor),
      .STROBE_O(stb), .EVENT_REQ_O(evt));
   initial begin
      clk = 1'b0;
      forever #2 clk = ~clk;
   end
   ////////////////////////////////////////////////////////////////////////
   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      comparisons++;
      if (got !== exp) begin
         error_cnt++;
         $display("CHECK FAILED t=%0t got %h exp %h", $time, got, exp);
      end
   endtask : chk
   // entered just after a rising edge; the watchdog ends a hang
   task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] wd);
      hsel <= 1'b1;
      htrans <= AES_HTRANS_NONSEQ;
      haddr <= {24'h000000, a};
      hwrite <= w;
      do @(posedge clk); while (hro !== 1'b1);
      hsel <= 1'b0;
      htrans <= 2'h0;
      hwdata <= wd;
      do @(posedge clk); while (hro !== 1'b1);
      d = hrdata;
   endtask : bus
   task automatic rd(input logic [7:0] a, input logic [31:0] e);
      bus(1'b0, a, 32'h00000000);
      chk(d, e);
   endtask : rd
   task automatic end_of_test;
      $display("comparisons %0d mismatches %0d", comparisons, error_cnt);
      if (error_cnt == 0 && comparisons > 0) $display("Regression OK");
      else $display("Regression broken");
      $finish;
   endtask : end_of_test
   ////////////////////////////////////////////////////////////////////////
   initial begin
      {rst, hsel, htrans, haddr, hwrite, hwdata} = {1'b1, 68'h0};
      {flt, prx, pnp, lnp, pan, msrc} = {5'h02, 8'h00};
      {vrf, llsrc, strap} = {8'hA5, 8'hFF, 8'h5C};
      {error_cnt, comparisons} = 64'h0;
      repeat (6) @(posedge clk);
      rst <= 1'b0;
      // strap lands at the first edge; look at the edge after it
      repeat (2) @(posedge clk);
      chk(32'(lor), 32'h0000005C);
      rd(AES_EXP_STATUS_OFS, 32'h00000004);
      pnp <= 1'b1;
      pan <= 1'b1;
      lnp <= 1'b0;
      @(posedge clk);
      bus(1'b1, AES_EXP_STATUS_OFS, 32'h0000FFFF);
      rd(AES_EXP_STATUS_OFS, 32'h00000009);
      $display("read-only status test done");
      {flt, prx} <= 2'h3;
      @(posedge clk);
      {flt, prx} <= 2'h0;
      rd(AES_EXP_STATUS_OFS, 32'h0000001B);
      rd(AES_EXP_STATUS_OFS, 32'h00000009);
      $display("latch high test done");
      llsrc <= 8'hF0;
      @(posedge clk);
      llsrc <= 8'hFF;
      rd(AES_GEN_STATUS_OFS, 32'h00000FA5);
      vrf <= 8'h3C;
      rd(AES_GEN_STATUS_OFS, 32'h0000003C);
      $display("virtual and latch low test done");
      msrc <= 8'h3C;
      @(posedge clk);
      msrc <= 8'h00;
      rd(AES_MASK_STATUS_OFS, 32'h0000003C);
      bus(1'b1, AES_MASK_STATUS_OFS, 32'h0000000C);
      rd(AES_MASK_STATUS_OFS, 32'h00000030);
      bus(1'b1, AES_INT_EN_OFS, 32'h00000020);
      rd(AES_INT_EN_OFS, 32'h00000020);
      chk(32'(evt), 32'h00000001);
      bus(1'b1, AES_INT_EN_OFS, 32'h00000001);
      repeat (2) @(posedge clk);
      chk(32'(evt), 32'h00000000);
      bus(1'b1, AES_MASK_STATUS_OFS, 32'h000000FF);
      rd(AES_MASK_STATUS_OFS, 32'h00000000);
      $display("mask and enable test done");
      bus(1'b1, AES_LOR_CFG_OFS, 32'h00000081);
      rd(AES_LOR_CFG_OFS, 32'h00000081);
      chk(32'(lor), 32'h00000081);
      bus(1'b1, AES_STROBE_CTRL_OFS, 32'h00000096);
      @(posedge clk);
      chk(32'(stb), 32'h00000096);
      rd(AES_STROBE_CTRL_OFS, 32'h00000000);
      rd(8'h20, 32'h00000000);
      chk(32'(hresp), 32'h00000000);
      $display("lor, strobe and unmapped test done");
      strap <= 8'h3A;
      rst <= 1'b1;
      repeat (6) @(posedge clk);
      rst <= 1'b0;
      repeat (2) @(posedge clk);
      chk(32'(lor), 32'h0000003A);
      rd(AES_LOR_CFG_OFS, 32'h0000003A);
      rd(AES_INT_EN_OFS, 32'h00000000);
      rd(AES_EXP_STATUS_OFS, 32'h00000009);
      $display("mid-run reset test done");
      end_of_test();
   end
   // the run needs about 70 cycles; this margin only cuts a hang
   initial begin
      #20000;
      error_cnt++;
      end_of_test();
   end
endmodule : aes_bank_tb_top
bind aes_bank aes_bank_chk chk_u (.MCLK_I(MCLK_I), .SYS_RST_I(SYS_RST_I), .HSEL_I(HSEL_I),
   .HADDR_I(HADDR_I), .HTRANS_I(HTRANS_I), .HWRITE_I(HWRITE_I), .HWDATA_I(HWDATA_I),
   .HREADY_I(HREADY_I), .HRDATA_O(HRDATA_O), .PAGE_RECEIVED_I(PAGE_RECEIVED_I),
   .PARALLEL_DETECT_FAULT_I(PARALLEL_DETECT_FAULT_I),
   .PARTNER_NEXT_PAGE_ABLE_I(PARTNER_NEXT_PAGE_ABLE_I),
   .LOCAL_NEXT_PAGE_ABLE_I(LOCAL_NEXT_PAGE_ABLE_I),
   .PARTNER_AUTONEG_ABLE_I(PARTNER_AUTONEG_ABLE_I),
   .VIRTUAL_READ_FIELD_I(VIRTUAL_READ_FIELD_I), .MASK_SRC_I(MASK_SRC_I),
   .STRAP_I(STRAP_I), .LOR_CFG_O(LOR_CFG_O), .STROBE_O(STROBE_O));
